// [verilog/ssf_defines.svh]
// Purpose: Offsets, field positions, reset values and codes of the socket status and force registers.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef SSF_DEFINES_SVH
`define SSF_DEFINES_SVH

`define SSF_OFF_EVENT       12'h000
`define SSF_OFF_PRESENT     12'h008
`define SSF_OFF_FORCE       12'h00c
`define SSF_OFF_CONTROL     12'h010

`define SSF_BIT_STSCHG      0
`define SSF_BIT_DET1        1
`define SSF_BIT_DET2        2
`define SSF_BIT_POWER       3
`define SSF_BIT_NARROW      4
`define SSF_BIT_WIDE        5
`define SSF_BIT_UNKNOWN     7
`define SSF_BIT_LOSS        8
`define SSF_BIT_BADREQ      9
`define SSF_CARD_LO         10
`define SSF_CARD_HI         13
`define SSF_BIT_RESENSE     14
`define SSF_SOCK_LO         28
`define SSF_SOCK_HI         31

`define SSF_CTRL_VCC_LO     4
`define SSF_CTRL_VCC_HI     6

`define SSF_RST_CAPS        4'h0
`define SSF_RST_EVENT       4'h0
`define SSF_RST_VCC         3'h0
`define SSF_PIN_IDLE        5'h06

`endif

// [verilog/ssf_pkg.sv]
// Purpose: Types shared by the socket status and force register block.
// Assumes: Constants live in ssf_defines.svh.
// Notes:   Voltage order in every 4-bit set is {Y.Y, X.X, 3.3, 5.0}.
package ssf_pkg;

    typedef enum logic [2:0]
    {
        SSF_VCC_OFF = 3'b000,
        SSF_VCC_5V0 = 3'b010,
        SSF_VCC_3V3 = 3'b011,
        SSF_VCC_XV  = 3'b100,
        SSF_VCC_YV  = 3'b101
    } ssf_vcc_t;

    typedef struct packed
    {
        logic [1:0] sense;      // Voltage-sense pins, 2 then 1.
        logic [1:0] detect_n;   // Card-detect pins, 2 then 1, low when seated.
        logic       stschg;     // Status-change pin.
    } ssf_pins_t;

    typedef struct packed
    {
        logic       unknown;
        logic       wide;
        logic       narrow;
        logic [3:0] caps;
    } ssf_card_t;

endpackage : ssf_pkg

// [verilog/ssf_sync.sv]
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs are levels from outside the clock domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module ssf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,     // Adapter clock.
    input  wire logic         sys_rst_i, // Synchronous reset, active high.
    input  wire logic [W-1:0] async_i,   // Raw pin levels.
    output logic      [W-1:0] sync_o     // Synchronised levels.
);
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic meta_q;
            logic stab_q;
            always_ff @(posedge clk_i)
            begin
                if (sys_rst_i)
                begin
                    meta_q <= 1'b0;
                    stab_q <= 1'b0;
                end
                else
                begin
                    meta_q <= async_i[g];
                    stab_q <= meta_q;
                end
            end
            assign sync_o[g] = stab_q;
        end
    endgenerate
endmodule : ssf_sync

// [verilog/ssf_regs.sv]
// Purpose: Socket present-state fields, force address, event flags and Vcc request check.
// Assumes: APB slave, 20 MHz clk_i, synchronous active-high reset, pins asynchronous.
// Notes:   Pins pass two flops before use; the bus answers with zero wait states.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ssf_defines.svh"
module ssf_regs (
    input  wire logic              clk_i,         // Adapter clock, 20 MHz.
    input  wire logic              sys_rst_i,     // Synchronous reset, active high.
    input  wire logic              psel,          // APB select.
    input  wire logic              penable,       // APB access phase.
    input  wire logic              pwrite,        // APB direction, 1 is write.
    input  wire logic [11:0]       paddr,         // APB byte address.
    input  wire logic [31:0]       pwdata,        // APB write data.
    output logic      [31:0]       prdata,        // APB read data.
    output logic                   pready,        // APB ready.
    output logic                   pslverr,       // APB error for unmapped address.
    input  wire ssf_pkg::ssf_pins_t pins_i,       // Socket pins, asynchronous.
    input  wire logic [3:0]        sock_caps_i,   // Supply capability straps, asynchronous.
    input  wire logic              xfer_busy_i,   // A card transfer is unfinished.
    input  wire logic              buf_pending_i, // Adapter buffers hold card data.
    output logic      [3:0]        vcc_en_o,      // One-hot Vcc select {Y,X,3.3,5.0}.
    output logic                   mode_wide_o,   // Socket set up for wide bus card.
    output logic                   mode_narrow_o  // Socket set up for 16-bit card.
);
    import ssf_pkg::*;

    // Own capability table, indexed by {sense2, sense1} for a seated card.
    function automatic ssf_card_t sense_decode(input logic [1:0] sense, input logic [1:0] det_n);
        ssf_card_t c;
        c = '{unknown: 1'b1, wide: 1'b0, narrow: 1'b0, caps: 4'h0};
        if (det_n == 2'b00)
        begin
            unique case (sense)
                2'b11: c = '{unknown: 1'b0, wide: 1'b0, narrow: 1'b1, caps: 4'h1};
                2'b10: c = '{unknown: 1'b0, wide: 1'b0, narrow: 1'b1, caps: 4'h3};
                2'b01: c = '{unknown: 1'b0, wide: 1'b1, narrow: 1'b0, caps: 4'h2};
                2'b00: c = '{unknown: 1'b1, wide: 1'b0, narrow: 1'b0, caps: 4'h0};
            endcase
        end
        return c;
    endfunction : sense_decode

    function automatic logic [3:0] vcc_onehot(input logic [2:0] code);
        logic [3:0] v;
        v = 4'h0;
        unique case (code)
            SSF_VCC_5V0: v = 4'h1;
            SSF_VCC_3V3: v = 4'h2;
            SSF_VCC_XV:  v = 4'h4;
            SSF_VCC_YV:  v = 4'h8;
            default:     v = 4'h0;
        endcase
        return v;
    endfunction : vcc_onehot

    ssf_pins_t  pins_s;
    logic [3:0] sock_s;
    logic [4:0] pins_raw;
    logic [4:0] pins_syn;

    // The synchroniser resets to zero, so the detect pins pass it flipped to make zero their empty-socket level.
    // Otherwise a phantom insertion and detect events would follow every reset.
    assign pins_raw = pins_i ^ `SSF_PIN_IDLE;
    assign pins_s   = ssf_pins_t'(pins_syn ^ `SSF_PIN_IDLE);

    ssf_sync #(.W(9)) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({sock_caps_i, pins_raw}),
        .sync_o    ({sock_s, pins_syn})
    );

    // State registers.
    logic [4:0]  prev_q;
    logic        power_q,   power_d;
    logic        narrow_q,  narrow_d;
    logic        wide_q,    wide_d;
    logic        unknown_q, unknown_d;
    logic        loss_q,    loss_d;
    logic        bad_q,     bad_d;
    logic [3:0]  caps_q,    caps_d;
    logic        block_q,   block_d;
    logic [3:0]  event_q,   event_d;
    logic [2:0]  vcc_req_q, vcc_req_d;
    logic [3:0]  vcc_en_q,  vcc_en_d;
    logic [31:0] rdata_q,   rdata_d;

    // Bus decode.
    logic setup_ph;
    logic access_ph;
    logic wr_acc;
    logic hit_event;
    logic hit_present;
    logic hit_force;
    logic hit_control;
    logic mapped;
    logic wr_event;
    logic wr_force;
    logic wr_control;

    assign setup_ph    = psel && !penable;
    assign access_ph   = psel && penable;
    assign wr_acc      = access_ph && pwrite;
    assign hit_event   = (paddr == `SSF_OFF_EVENT);
    assign hit_present = (paddr == `SSF_OFF_PRESENT);
    assign hit_force   = (paddr == `SSF_OFF_FORCE);
    assign hit_control = (paddr == `SSF_OFF_CONTROL);
    assign mapped      = hit_event || hit_present || hit_force || hit_control;
    assign wr_event    = wr_acc && hit_event;
    assign wr_force    = wr_acc && hit_force;
    assign wr_control  = wr_acc && hit_control;

    assign pready  = 1'b1;
    assign pslverr = access_ph && !mapped;
    assign prdata  = rdata_q;

    // Pin events.
    logic       seated;
    logic       was_seated;
    logic       insert_ev;
    logic       removal_ev;
    logic       stschg_rise;
    logic [1:0] det_change;
    ssf_card_t  sensed;

    assign seated      = (pins_s.detect_n == 2'b00);
    assign was_seated  = (prev_q[2:1] == 2'b00);
    assign insert_ev   = seated && !was_seated;
    assign removal_ev  = !seated && was_seated;
    assign stschg_rise = pins_s.stschg && !prev_q[0];
    assign det_change  = pins_s.detect_n ^ prev_q[2:1];
    assign sensed      = sense_decode(pins_s.sense, pins_s.detect_n);

    // Force word fields.
    logic        f_resense;
    logic        f_type_ok;
    logic [3:0]  f_caps;
    assign f_resense = wr_force && pwdata[`SSF_BIT_RESENSE];
    assign f_type_ok = wr_force && !seated;
    assign f_caps    = pwdata[`SSF_CARD_HI:`SSF_CARD_LO];

    // Vcc request check on a control write.
    logic [2:0] req_code;
    logic [3:0] req_hot;
    logic       req_off;
    logic       req_legal;
    assign req_code  = pwdata[`SSF_CTRL_VCC_HI:`SSF_CTRL_VCC_LO];
    assign req_hot   = vcc_onehot(req_code);
    assign req_off   = (req_code == SSF_VCC_OFF);
    assign req_legal = seated && !block_q
                       && ((req_hot & caps_q & sock_s) != 4'h0)
                       && !(wide_q && req_hot[0]);

    // Event flags: hardware sets always win over the write-one clear.
    logic [3:0] event_set;
    assign event_set[0] = stschg_rise || (wr_force && pwdata[`SSF_BIT_STSCHG]);
    assign event_set[1] = det_change[0] || (wr_force && pwdata[`SSF_BIT_DET1]);
    assign event_set[2] = det_change[1] || (wr_force && pwdata[`SSF_BIT_DET2]);
    assign event_set[3] = (wr_control && !req_off)
                          || (wr_force && pwdata[`SSF_BIT_POWER]);

    always_comb
    begin
        event_d = event_q;
        if (wr_event)
        begin
            event_d = event_q & ~pwdata[3:0];
        end
        event_d = event_d | event_set;
    end

    // Present-state fields: forced value first, real hardware after, so it wins.
    always_comb
    begin
        narrow_d  = narrow_q;
        wide_d    = wide_q;
        unknown_d = unknown_q;
        loss_d    = loss_q;
        bad_d     = bad_q;
        caps_d    = caps_q;
        block_d   = block_q;
        power_d   = power_q;
        vcc_req_d = vcc_req_q;
        vcc_en_d  = vcc_en_q;
        if (f_type_ok)
        begin
            narrow_d  = pwdata[`SSF_BIT_NARROW];
            wide_d    = pwdata[`SSF_BIT_WIDE];
            unknown_d = pwdata[`SSF_BIT_UNKNOWN];
        end
        if (wr_force)
        begin
            loss_d = pwdata[`SSF_BIT_LOSS];
            bad_d  = pwdata[`SSF_BIT_BADREQ];
            caps_d = f_caps;
            if (f_caps != 4'h0)
            begin
                block_d = 1'b1;
            end
        end
        // A resense in the same write overrides the forced capability.
        if (f_resense)
        begin
            caps_d  = sensed.caps;
            block_d = 1'b0;
        end
        if (wr_control)
        begin
            vcc_req_d = req_code;
            if (req_off)
            begin
                power_d  = 1'b0;
                vcc_en_d = 4'h0;
            end
            else if (req_legal)
            begin
                power_d  = 1'b1;
                vcc_en_d = req_hot;
            end
            else
            begin
                power_d  = 1'b0;
                vcc_en_d = 4'h0;
                bad_d    = 1'b1;
            end
        end
        if (insert_ev)
        begin
            narrow_d  = sensed.narrow;
            wide_d    = sensed.wide;
            unknown_d = sensed.unknown;
            caps_d    = sensed.caps;
            block_d   = 1'b0;
        end
        // Losing a card mid-transfer beats any forced clear of the flag.
        if (removal_ev)
        begin
            power_d  = 1'b0;
            vcc_en_d = 4'h0;
            if (xfer_busy_i || buf_pending_i)
            begin
                loss_d = 1'b1;
            end
        end
    end

    // Read data is captured in the setup cycle so prdata comes from a flop.
    logic [31:0] present_word;
    always_comb
    begin
        present_word                             = 32'h0000_0000;
        present_word[`SSF_BIT_STSCHG]            = pins_s.stschg;
        present_word[`SSF_BIT_DET2:`SSF_BIT_DET1] = pins_s.detect_n;
        present_word[`SSF_BIT_POWER]             = power_q;
        present_word[`SSF_BIT_NARROW]            = narrow_q;
        present_word[`SSF_BIT_WIDE]              = wide_q;
        present_word[`SSF_BIT_UNKNOWN]           = unknown_q;
        present_word[`SSF_BIT_LOSS]              = loss_q;
        present_word[`SSF_BIT_BADREQ]            = bad_q;
        present_word[`SSF_CARD_HI:`SSF_CARD_LO]  = caps_q;
        present_word[`SSF_SOCK_HI:`SSF_SOCK_LO]  = sock_s;
    end

    always_comb
    begin
        rdata_d = rdata_q;
        if (setup_ph)
        begin
            rdata_d = 32'h0000_0000;
            if (!pwrite && hit_event)
            begin
                rdata_d[3:0] = event_q;
            end
            else if (!pwrite && hit_present)
            begin
                rdata_d = present_word;
            end
            else if (!pwrite && hit_control)
            begin
                rdata_d[`SSF_CTRL_VCC_HI:`SSF_CTRL_VCC_LO] = vcc_req_q;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            prev_q    <= `SSF_PIN_IDLE;
            power_q   <= 1'b0;
            narrow_q  <= 1'b0;
            wide_q    <= 1'b0;
            unknown_q <= 1'b0;
            loss_q    <= 1'b0;
            bad_q     <= 1'b0;
            caps_q    <= `SSF_RST_CAPS;
            block_q   <= 1'b0;
            event_q   <= `SSF_RST_EVENT;
            vcc_req_q <= `SSF_RST_VCC;
            vcc_en_q  <= 4'h0;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            prev_q    <= pins_s;
            power_q   <= power_d;
            narrow_q  <= narrow_d;
            wide_q    <= wide_d;
            unknown_q <= unknown_d;
            loss_q    <= loss_d;
            bad_q     <= bad_d;
            caps_q    <= caps_d;
            block_q   <= block_d;
            event_q   <= event_d;
            vcc_req_q <= vcc_req_d;
            vcc_en_q  <= vcc_en_d;
            rdata_q   <= rdata_d;
        end
    end

    assign vcc_en_o      = vcc_en_q;
    assign mode_wide_o   = wide_q;
    assign mode_narrow_o = narrow_q;

endmodule : ssf_regs

// [tb/ssf_card_model.sv]
// Purpose: Behavioural card at the socket's detect, sense and status-change pins.
// Assumes: Pins change just after a clock edge.
// Notes:   An empty socket shows its sense pins at the pull-up level.
`timescale 1ns/1ps
module ssf_card_model (
    input  wire logic          clk_i,    // Times the pin changes.
    input  wire logic          seated_i, // Card fully in.
    input  wire logic [1:0]    sense_i,  // Sense code of the card.
    input  wire logic          stschg_i, // Status-change level.
    output ssf_pkg::ssf_pins_t pins_o    // Socket pins.
);
    import ssf_pkg::*;
    initial pins_o = 5'h1e;
    always @(posedge clk_i)
    begin
        pins_o.sense    <= seated_i ? sense_i : 2'b11;
        pins_o.detect_n <= seated_i ? 2'b00 : 2'b11;
        pins_o.stschg   <= seated_i & stschg_i;
    end
endmodule : ssf_card_model

// [tb/ssf_regs_checker.sv]
// Purpose: Port checks of the socket status and force registers.
// Assumes: One clock domain.
// Notes:   Bound to ssf_regs below.
`timescale 1ns/1ps
`include "ssf_defines.svh"
module ssf_regs_checker (
    input wire logic               clk_i,         // Clock.
    input wire logic               sys_rst_i,     // Reset.
    input wire logic               psel,          // Select.
    input wire logic               penable,       // Access.
    input wire logic               pwrite,        // Write.
    input wire logic [11:0]        paddr,         // Address.
    input wire logic [31:0]        pwdata,        // Write data.
    input wire logic [31:0]        prdata,        // Read data.
    input wire logic               pready,        // Ready.
    input wire logic               pslverr,       // Error.
    input wire ssf_pkg::ssf_pins_t pins_i,        // Pins.
    input wire logic [3:0]         sock_caps_i,   // Straps.
    input wire logic               xfer_busy_i,   // Open transfer.
    input wire logic               buf_pending_i, // Buffered data.
    input wire logic [3:0]         vcc_en_o,      // Vcc select.
    input wire logic               mode_wide_o,   // Wide mode.
    input wire logic               mode_narrow_o  // Narrow mode.
);
    import ssf_pkg::*;
    wire logic rd_w  = psel && penable && !pwrite;
    wire logic ctl_w = psel && penable && pwrite && paddr == `SSF_OFF_CONTROL;
    wire logic map_w = paddr inside {`SSF_OFF_EVENT, `SSF_OFF_PRESENT, `SSF_OFF_FORCE, `SSF_OFF_CONTROL};
    wire logic frc_w = psel && penable && pwrite && paddr == `SSF_OFF_FORCE;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (psel && penable && !map_w |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (psel && penable && map_w |-> !pslverr)
        else $error("mapped access refused");
    a_force_reads0: assert property (rd_w && paddr == `SSF_OFF_FORCE |-> prdata == 32'h0)
        else $error("force address returned data");
    a_reserved_zero: assert property (rd_w && paddr == `SSF_OFF_PRESENT |-> prdata[27:14] == 14'h0 && !prdata[6])
        else $error("reserved state bits set");
    // Software may force both type flags on an empty socket, so only changes made by hardware are held to this.
    a_mode_excl: assert property ($changed({mode_wide_o, mode_narrow_o}) && !$past(frc_w) |-> !(mode_wide_o && mode_narrow_o))
        else $error("both card modes set");
    a_vcc_onehot: assert property ($onehot0(vcc_en_o))
        else $error("more than one Vcc selected");
    a_wide_no_five: assert property (mode_wide_o |-> !vcc_en_o[0])
        else $error("wide card at five volt");
    a_removal_off: assert property ((pins_i.detect_n != 2'b00) [*6] |-> vcc_en_o == 4'h0)
        else $error("Vcc on with no card seated");
    a_vcc_by_ctrl: assert property (vcc_en_o != 4'h0 && vcc_en_o != $past(vcc_en_o)
        |-> $past(ctl_w) || $past(ctl_w, 2))
        else $error("Vcc applied without a request");
endmodule : ssf_regs_checker
bind ssf_regs ssf_regs_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_i(pins_i), .sock_caps_i(sock_caps_i), .xfer_busy_i(xfer_busy_i), .buf_pending_i(buf_pending_i),
    .vcc_en_o(vcc_en_o), .mode_wide_o(mode_wide_o), .mode_narrow_o(mode_narrow_o));

// [tb/ssf_testbench.sv]
// Purpose: Self-checking bench for the socket status and force registers.
// Assumes: APB master with an idle cycle between transfers; card model on the pins.
// Notes:   Pin changes get five cycles to pass the model and the synchronisers.
`timescale 1ns/1ps
`include "ssf_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench;
    import ssf_pkg::*;
    localparam logic [11:0] EV = `SSF_OFF_EVENT;
    localparam logic [11:0] PS = `SSF_OFF_PRESENT;
    localparam logic [11:0] FW = `SSF_OFF_FORCE;
    localparam logic [11:0] CT = `SSF_OFF_CONTROL;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        pready, pslverr, rerr, wide, narrow;
    logic        busy = 1'b0, pend = 1'b0, seated = 1'b0, stschg = 1'b0;
    logic [1:0]  sense = 2'b00;
    logic [3:0]  sock_caps = 4'h3, vcc_en;
    ssf_pins_t   pins;
    int          n_mismatch = 0;
    int          checks = 0;
    always #25 clk_i = ~clk_i;
    ssf_card_model u_card (.clk_i(clk_i), .seated_i(seated), .sense_i(sense), .stschg_i(stschg), .pins_o(pins));
    ssf_regs DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_i(pins),
        .sock_caps_i(sock_caps), .xfer_busy_i(busy), .buf_pending_i(pend), .vcc_en_o(vcc_en),
        .mode_wide_o(wide), .mode_narrow_o(narrow));
    task automatic summarize;
        $display("Counts: %0d mismatches in %0d checks", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20)
        begin
            n_mismatch++;
            summarize();
        end
        rdata   = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask : rd_chk
    task automatic settle;
        repeat (5) @(posedge clk_i);
    endtask : settle
    // Outputs are looked at mid-cycle so the edge's own updates have landed.
    task automatic vcc_is(input logic [3:0] e);
        @(negedge clk_i);
        `CHK(vcc_en, e)
        @(posedge clk_i);
    endtask : vcc_is
    initial
    begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        settle();
        rd_chk(PS, 32'h3000_0006);
        wr(EV, 32'hf);
        wr(FW, 32'hffff_9751);
        rd_chk(PS, 32'h3000_1716);
        rd_chk(EV, 32'h1);
        rd_chk(FW, 32'h0);
        wr(EV, 32'hf);
        wr(FW, 32'he);
        rd_chk(EV, 32'he);
        rd_chk(PS, 32'h3000_0006);
        wr(EV, 32'hf);
        sense  <= 2'b10;
        seated <= 1'b1;
        settle();
        rd_chk(PS, 32'h3000_0c10);
        rd_chk(EV, 32'h6);
        `CHK(narrow, 1'b1)
        wr(FW, 32'h0000_4c20);
        rd_chk(PS, 32'h3000_0c10);
        wr(CT, 32'h30);
        vcc_is(4'h2);
        rd_chk(PS, 32'h3000_0c18);
        wr(CT, 32'h40);
        vcc_is(4'h0);
        rd_chk(PS, 32'h3000_0e10);
        wr(FW, 32'h0000_0c00);
        wr(CT, 32'h20);
        vcc_is(4'h0);
        wr(FW, 32'h0000_4000);
        wr(CT, 32'h20);
        vcc_is(4'h1);
        busy   <= 1'b1;
        seated <= 1'b0;
        settle();
        vcc_is(4'h0);
        apb(1'b0, PS, 32'h0);
        `CHK({rdata[8], rdata[3:1]}, 4'hb)
        busy <= 1'b0;
        wr(FW, 32'h0);
        apb(1'b0, PS, 32'h0);
        `CHK(rdata[8], 1'b0)
        sense  <= 2'b01;
        seated <= 1'b1;
        settle();
        rd_chk(PS, 32'h3000_0820);
        `CHK(wide, 1'b1)
        wr(CT, 32'h20);
        vcc_is(4'h0);
        wr(CT, 32'h50);
        vcc_is(4'h0);
        wr(CT, 32'h30);
        vcc_is(4'h2);
        wr(FW, 32'h0000_3c00);
        pend   <= 1'b1;
        seated <= 1'b0;
        settle();
        pend   <= 1'b0;
        seated <= 1'b1;
        settle();
        apb(1'b0, PS, 32'h0);
        `CHK(rdata[13:8], 6'h09)
        wr(CT, 32'h30);
        vcc_is(4'h2);
        stschg    <= 1'b1;
        sock_caps <= 4'h9;
        settle();
        apb(1'b0, PS, 32'h0);
        `CHK({rdata[31:28], rdata[0]}, 5'h13)
        apb(1'b0, EV, 32'h0);
        `CHK(rdata[0], 1'b1)
        apb(1'b0, 12'h004, 32'h0);
        `CHK({rerr, rdata}, {1'b1, 32'h0})
        summarize();
    end
endmodule : testbench
